// >>> logic/ddc_params.svh
// Constants for the dual converter mode and update control
//
// Notes on behaviour
// R1 - At power-up both outputs sit at zero scale, or midscale when level select high.
// R2 - Outputs hold their power-up level until the first valid complete write frame.
// R3 - Command 0111 resets converters to the code picked by level select.
// R4 - Command 0100 applies the power mode field to the selected channels.
// R5 - Mode bits 9:8: 00 normal, 01 1k to ground, 10 100k, 11 three-state.
// R6 - Power-down never alters stored converter register contents.
// R7 - Power command bit 3 selects channel B, bit 0 selects channel A.
// R8 - On power-up output takes input register if strobe low, else old converter value.
// R9 - Leaving power-down allows about 4.5 us before output counts as valid.
// R10 - Clear falling edge loads every input and converter register with the clear code.
// R11 - Clear field bits 1:0: 00 zero, 01 0x8000, 10 0xFFFF, 11 no operation.
// R12 - Command 0101 loads the clear field; it starts at the zero code.
// R13 - Cleared state ends on the 32nd falling clock edge of the next valid frame.
// R14 - Clear asserted during a frame aborts and discards that frame.
// R15 - With strobe low, converter registers update on the 32nd falling clock edge.
// R16 - In chain mode the host pulses the strobe rather than holding it low.
// R17 - With strobe high writes touch input registers; strobe falling copies them over.
// R18 - Command 0010 writes the addressed input register then updates all channels.
// R19 - Command 0110 stores override bits 3 and 0; a set bit treats strobe as low.
// R20 - While lockout is low every software power-down request is refused.
// R21 - Lockout falling during a frame aborts that frame at once.
// R22 - The host should tie lockout to a fixed level, not toggle it.
// R23 - Frames are 32 bits MSB first: 4 ignored, command, address, data, padding.
// R24 - Select rising before bit 32 resets the shifter with no update or mode change.
// R25 - Lockout falling while channels are down returns every mode to normal; a clear edge in the same cycle with clear field not 11 leaves modes unchanged.
// R26 - Aborted frames change nothing; the next select fall starts a fresh frame.
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

`define DDC_FRAME_BITS 6'h20
`define DDC_CMD_MSB 27
`define DDC_CMD_LSB 24
`define DDC_ADDR_MSB 23
`define DDC_ADDR_LSB 20
`define DDC_DATA_MSB 19
`define DDC_DATA_LSB 4
`define DDC_MODE_MSB 9
`define DDC_MODE_LSB 8
`define DDC_CHAN_B_BIT 3
`define DDC_CHAN_A_BIT 0
`define DDC_CLR_MSB 1
`define DDC_CLR_LSB 0
`define DDC_CHAIN_BIT 1
`define DDC_ADDR_A 4'h0
`define DDC_ADDR_B 4'h3
`define DDC_ADDR_BOTH 4'hF
`define DDC_CODE_ZERO 16'h0000
`define DDC_CODE_MID 16'h8000
`define DDC_CODE_FULL 16'hFFFF
`define DDC_CLR_SEL_RESET 2'h0
`define DDC_MODE_NORMAL 2'h0
`define DDC_CLK_MHZ 200
`define DDC_WAKE_NS 4500
`define DDC_WAKE_CYCLES ((`DDC_WAKE_NS * `DDC_CLK_MHZ) / 1000)

`endif

// >>> logic/ddc_pkg.sv
// Types for the dual converter mode and update control
package ddc_pkg;
    typedef enum logic [3:0] {
        DDC_CMD_WRITE_IN = 4'h0,
        DDC_CMD_UPDATE = 4'h1,
        DDC_CMD_WRITE_ALL = 4'h2,
        DDC_CMD_WRITE_UPD = 4'h3,
        DDC_CMD_POWER = 4'h4,
        DDC_CMD_CLR_CODE = 4'h5,
        DDC_CMD_OVERRIDE = 4'h6,
        DDC_CMD_RESET = 4'h7,
        DDC_CMD_CHAIN = 4'h8
    } ddc_cmd_type;

    typedef enum {
        DDC_IDLE,
        DDC_SHIFT,
        DDC_DONE
    } ddc_frame_type;
endpackage : ddc_pkg

// >>> logic/ddc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ddc_sync (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    always_comb begin
        next_stage = {stage[1:0], pin};
        // Stage 0 is only read by stage 1
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage <= 3'h7;
            level <= 1'b1;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule : ddc_sync
`default_nettype wire

// >>> logic/ddc_channel.sv
// One converter channel: input, converter and mode registers
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"
module ddc_channel (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic init_load,
    input wire logic [15:0] init_code,
    input wire logic in_we,
    input wire logic [15:0] in_data,
    input wire logic dac_upd,
    input wire logic clear_load,
    input wire logic [15:0] clear_code,
    input wire logic mode_we,
    input wire logic [1:0] mode_data,
    input wire logic wake_from_input,
    output logic [15:0] in_reg,
    output logic [15:0] dac_reg,
    output logic [1:0] mode
);
    logic [15:0] next_in;
    logic [15:0] next_dac;
    logic [1:0] next_mode;

    always_comb begin
        next_in = in_reg;
        next_dac = dac_reg;
        next_mode = mode;
        if (init_load) begin
            next_in = init_code;
            next_dac = init_code;
            next_mode = `DDC_MODE_NORMAL;
        end else if (clear_load) begin
            next_in = clear_code; // R10
            next_dac = clear_code; // R10
        end else begin
            if (in_we)
                next_in = in_data;
            if (dac_upd)
                next_dac = in_we ? in_data : in_reg;
            if (mode_we) begin
                next_mode = mode_data;
                // R6 keeps the converter register; R8 picks the wake value
                if (mode_data == `DDC_MODE_NORMAL && mode != `DDC_MODE_NORMAL
                    && wake_from_input)
                    next_dac = in_reg; // R8
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            in_reg <= `DDC_CODE_ZERO;
            dac_reg <= `DDC_CODE_ZERO;
            mode <= `DDC_MODE_NORMAL;
        end else begin
            in_reg <= next_in;
            dac_reg <= next_dac;
            mode <= next_mode;
        end
    end
endmodule : ddc_channel
`default_nettype wire

// >>> logic/ddc_top.sv
// Serial frame receiver and mode/update control for two converter channels
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"
module ddc_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic select_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    input wire logic load_outputs_n,
    input wire logic async_clear_n,
    input wire logic powerdown_lockout_n,
    input wire logic por_level,
    output logic [15:0] out_code_a,
    output logic [15:0] out_code_b,
    output logic [1:0] out_mode_a,
    output logic [1:0] out_mode_b,
    output logic out_valid_a,
    output logic out_valid_b,
    output logic cleared,
    output logic chain_enable
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic sel_s, clk_s, din_s, ld_s, clr_s, pdl_s;
    ddc_sync u_sel (.core_clk(core_clk), .rstn(rstn), .pin(select_n), .level(sel_s));
    ddc_sync u_sck (.core_clk(core_clk), .rstn(rstn), .pin(serial_clk), .level(clk_s));
    ddc_sync u_din (.core_clk(core_clk), .rstn(rstn), .pin(serial_din), .level(din_s));
    ddc_sync u_ld (.core_clk(core_clk), .rstn(rstn), .pin(load_outputs_n), .level(ld_s));
    ddc_sync u_clr (.core_clk(core_clk), .rstn(rstn), .pin(async_clear_n), .level(clr_s));
    ddc_sync u_pdl (.core_clk(core_clk), .rstn(rstn), .pin(powerdown_lockout_n),
                    .level(pdl_s));

    logic sel_d, clk_d, ld_d, clr_d, pdl_d;
    logic started;
    logic next_started;
    logic sel_fall, sel_rise, sck_fall, ld_fall, clr_fall, pdl_fall;
    assign sel_fall = sel_d & ~sel_s;
    assign sel_rise = ~sel_d & sel_s;
    assign sck_fall = clk_d & ~clk_s;
    assign ld_fall = ld_d & ~ld_s;
    assign clr_fall = clr_d & ~clr_s;
    assign pdl_fall = pdl_d & ~pdl_s;

    // ************************************************************
    // Frame shifter
    // ************************************************************
    ddc_pkg::ddc_frame_type fstate, next_fstate;
    logic [31:0] shreg, next_shreg;
    logic [5:0] bitcnt, next_bitcnt;
    logic frame_exec;
    logic frame_abort;

    // Clear and lockout edges kill the frame in flight
    assign frame_abort = clr_fall | pdl_fall; // R14 R21

    always_comb begin
        next_fstate = fstate;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        frame_exec = 1'b0;
        case (fstate)
            ddc_pkg::DDC_IDLE: begin
                if (sel_fall && !frame_abort) begin
                    next_fstate = ddc_pkg::DDC_SHIFT; // R26
                    next_shreg = 32'h0000_0000;
                    next_bitcnt = 6'h00;
                end
            end
            ddc_pkg::DDC_SHIFT: begin
                if (frame_abort || sel_rise) begin
                    next_fstate = ddc_pkg::DDC_IDLE; // R24
                    next_shreg = 32'h0000_0000;
                    next_bitcnt = 6'h00;
                end else if (sck_fall) begin
                    next_shreg = {shreg[30:0], din_s}; // R23
                    next_bitcnt = bitcnt + 6'h01;
                    if (bitcnt + 6'h01 == `DDC_FRAME_BITS) begin
                        next_fstate = ddc_pkg::DDC_DONE;
                        frame_exec = 1'b1; // R15
                    end
                end
            end
            ddc_pkg::DDC_DONE: begin
                // Extra clocks are ignored until select rises
                if (sel_rise || frame_abort)
                    next_fstate = ddc_pkg::DDC_IDLE;
            end
            default: next_fstate = ddc_pkg::DDC_IDLE;
        endcase
    end

    // Word that completes on this edge
    logic [31:0] word;
    assign word = {shreg[30:0], din_s};
    ddc_pkg::ddc_cmd_type cmd;
    assign cmd = ddc_pkg::ddc_cmd_type'(word[`DDC_CMD_MSB:`DDC_CMD_LSB]);
    logic [3:0] addr;
    assign addr = word[`DDC_ADDR_MSB:`DDC_ADDR_LSB];
    logic [15:0] data;
    assign data = word[`DDC_DATA_MSB:`DDC_DATA_LSB];

    // ************************************************************
    // Command decode
    // ************************************************************
    logic [1:0] clear_sel, next_clear_sel;
    logic [1:0] override, next_override;
    logic next_cleared, next_chain;
    logic init_pending, next_init_pending;
    logic [1:0] in_we, dac_upd, mode_we, clear_load;
    logic init_load;
    logic [15:0] clear_code;
    logic [15:0] por_code;
    logic [15:0] in_a, in_b, dac_a, dac_b;
    logic [1:0] mode_a, mode_b;
    logic [1:0] mode_data;
    logic sel_a, sel_b;

    assign por_code = por_level ? `DDC_CODE_MID : `DDC_CODE_ZERO; // R1
    assign sel_a = (addr == `DDC_ADDR_A) || (addr == `DDC_ADDR_BOTH);
    assign sel_b = (addr == `DDC_ADDR_B) || (addr == `DDC_ADDR_BOTH);

    always_comb begin
        case (clear_sel)
            2'h0: clear_code = `DDC_CODE_ZERO; // R11
            2'h1: clear_code = `DDC_CODE_MID;
            default: clear_code = `DDC_CODE_FULL;
        endcase
    end

    always_comb begin
        logic [1:0] eff_ld;
        logic [1:0] chan;
        eff_ld = {override[1] | ~ld_s, override[0] | ~ld_s}; // R19
        chan = {word[`DDC_CHAN_B_BIT], word[`DDC_CHAN_A_BIT]}; // R7
        next_clear_sel = clear_sel;
        next_override = override;
        next_cleared = cleared;
        next_chain = chain_enable;
        next_init_pending = init_pending;
        in_we = 2'b00;
        dac_upd = 2'b00;
        mode_we = 2'b00;
        mode_data = word[`DDC_MODE_MSB:`DDC_MODE_LSB]; // R5
        clear_load = 2'b00;
        init_load = init_pending;
        if (init_pending)
            next_init_pending = 1'b0; // R1 R2
        // Clear wins over every other event in the same cycle
        if (clr_fall && clear_sel != 2'h3) begin
            clear_load = 2'b11; // R10
            next_cleared = 1'b1;
            mode_we = 2'b11; // No effect: the channel gives clear_load priority over mode_we, so modes are kept
            mode_data = `DDC_MODE_NORMAL;
        end else if (pdl_fall) begin
            mode_we = 2'b11; // R25
            mode_data = `DDC_MODE_NORMAL;
        end else if (frame_exec) begin
            next_cleared = 1'b0; // R13
            case (cmd)
                ddc_pkg::DDC_CMD_WRITE_IN: begin
                    in_we = {sel_b, sel_a};
                    dac_upd = {sel_b, sel_a} & eff_ld; // R15
                end
                ddc_pkg::DDC_CMD_UPDATE: dac_upd = {sel_b, sel_a};
                ddc_pkg::DDC_CMD_WRITE_ALL: begin
                    in_we = {sel_b, sel_a};
                    dac_upd = 2'b11; // R18
                end
                ddc_pkg::DDC_CMD_WRITE_UPD: begin
                    in_we = {sel_b, sel_a};
                    dac_upd = {sel_b, sel_a};
                end
                ddc_pkg::DDC_CMD_POWER: begin
                    // Lockout refuses only requests that enter power-down
                    if (pdl_s || mode_data == `DDC_MODE_NORMAL)
                        mode_we = chan; // R4 R20
                end
                ddc_pkg::DDC_CMD_CLR_CODE:
                    next_clear_sel = word[`DDC_CLR_MSB:`DDC_CLR_LSB]; // R12
                ddc_pkg::DDC_CMD_OVERRIDE: next_override = chan; // R19
                ddc_pkg::DDC_CMD_RESET: init_load = 1'b1; // R3
                ddc_pkg::DDC_CMD_CHAIN: next_chain = word[`DDC_CHAIN_BIT];
                default: ;
            endcase
        end
        // A strobe edge must not be lost to a frame ending in the same cycle;
        // clear still wins, and a lockout edge keeps its own precedence
        if (ld_fall && clear_load == 2'b00 && !pdl_fall) begin
            dac_upd = 2'b11; // R17
        end
        if (init_load && !init_pending) begin
            next_override = 2'b00;
            next_clear_sel = `DDC_CLR_SEL_RESET;
            next_chain = 1'b0;
        end
    end

    ddc_channel u_chan_a (
        .core_clk(core_clk), .rstn(rstn), .init_load(init_load), .init_code(por_code),
        .in_we(in_we[0]), .in_data(data), .dac_upd(dac_upd[0]),
        .clear_load(clear_load[0]), .clear_code(clear_code),
        .mode_we(mode_we[0]), .mode_data(mode_data), .wake_from_input(~ld_s),
        .in_reg(in_a), .dac_reg(dac_a), .mode(mode_a)
    );
    ddc_channel u_chan_b (
        .core_clk(core_clk), .rstn(rstn), .init_load(init_load), .init_code(por_code),
        .in_we(in_we[1]), .in_data(data), .dac_upd(dac_upd[1]),
        .clear_load(clear_load[1]), .clear_code(clear_code),
        .mode_we(mode_we[1]), .mode_data(mode_data), .wake_from_input(~ld_s),
        .in_reg(in_b), .dac_reg(dac_b), .mode(mode_b)
    );

    // ************************************************************
    // Wake timers
    // ************************************************************
    // Restarted on every wake, so a quick sleep and wake never shows valid early
    localparam int WAKE_CYC = `DDC_WAKE_CYCLES;
    logic [10:0] wake_a, wake_b, next_wake_a, next_wake_b;
    always_comb begin
        next_wake_a = (wake_a != 11'h000) ? wake_a - 11'h001 : 11'h000;
        next_wake_b = (wake_b != 11'h000) ? wake_b - 11'h001 : 11'h000;
        if (out_mode_a != `DDC_MODE_NORMAL && mode_a == `DDC_MODE_NORMAL)
            next_wake_a = 11'(WAKE_CYC); // R9
        if (out_mode_b != `DDC_MODE_NORMAL && mode_b == `DDC_MODE_NORMAL)
            next_wake_b = 11'(WAKE_CYC);
        next_started = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fstate <= ddc_pkg::DDC_IDLE;
            shreg <= 32'h0000_0000;
            bitcnt <= 6'h00;
            sel_d <= 1'b1;
            clk_d <= 1'b1;
            ld_d <= 1'b1;
            clr_d <= 1'b1;
            pdl_d <= 1'b1;
            started <= 1'b0;
            init_pending <= 1'b1;
            clear_sel <= `DDC_CLR_SEL_RESET;
            override <= 2'b00;
            cleared <= 1'b0;
            chain_enable <= 1'b0;
            wake_a <= 11'h000;
            wake_b <= 11'h000;
            out_code_a <= `DDC_CODE_ZERO;
            out_code_b <= `DDC_CODE_ZERO;
            out_mode_a <= `DDC_MODE_NORMAL;
            out_mode_b <= `DDC_MODE_NORMAL;
            out_valid_a <= 1'b0;
            out_valid_b <= 1'b0;
        end else begin
            fstate <= next_fstate;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            sel_d <= sel_s;
            clk_d <= clk_s;
            ld_d <= ld_s;
            clr_d <= clr_s;
            pdl_d <= pdl_s;
            started <= next_started;
            init_pending <= next_init_pending & ~started;
            clear_sel <= next_clear_sel;
            override <= next_override;
            cleared <= next_cleared;
            chain_enable <= next_chain;
            wake_a <= next_wake_a;
            wake_b <= next_wake_b;
            out_code_a <= dac_a;
            out_code_b <= dac_b;
            out_mode_a <= mode_a;
            out_mode_b <= mode_b;
            out_valid_a <= started && mode_a == `DDC_MODE_NORMAL && next_wake_a == 11'h000;
            out_valid_b <= started && mode_b == `DDC_MODE_NORMAL && next_wake_b == 11'h000;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    // Frame-end checks without their own clr_fall and pdl_fall terms rely on frame_exec already excluding both abort edges
    a_clear_loads: assert property (@(posedge core_clk) disable iff (!rstn) // R10
        clr_fall && clear_sel == 2'h1 |=> in_a == 16'h8000 && dac_b == 16'h8000)
        else $error("clear did not load clear code");
    a_abort_frame: assert property (@(posedge core_clk) disable iff (!rstn) // R14
        frame_abort |-> !frame_exec ##1 fstate == ddc_pkg::DDC_IDLE)
        else $error("aborted frame executed");
    a_lockout_hold: assert property (@(posedge core_clk) disable iff (!rstn) // R20
        !pdl_s && !$past(pdl_s) && mode_a == 2'h0 |=> mode_a == 2'h0)
        else $error("power-down passed lockout");
    a_lock_wake: assert property (@(posedge core_clk) disable iff (!rstn) // R25
        pdl_fall |=> mode_a == 2'h0 && mode_b == 2'h0)
        else $error("lockout edge did not wake");
    a_sel_interrupt: assert property (@(posedge core_clk) disable iff (!rstn) // R24
        fstate == ddc_pkg::DDC_SHIFT && sel_rise |=> fstate == ddc_pkg::DDC_IDLE
        && bitcnt == 6'h00)
        else $error("select rise did not reset shifter");
    // A strobe edge in the same cycle may legally move the converter register
    a_pd_keeps_dac: assert property (@(posedge core_clk) disable iff (!rstn) // R6
        frame_exec && cmd == ddc_pkg::DDC_CMD_POWER && !clr_fall && !pdl_fall && !ld_fall
        && !init_pending && mode_data != 2'h0
        |=> $stable(dac_a) && $stable(dac_b))
        else $error("power-down changed converter register");
    a_sync_update: assert property (@(posedge core_clk) disable iff (!rstn) // R15
        frame_exec && cmd == ddc_pkg::DDC_CMD_WRITE_IN && addr == 4'h0 && !ld_s
        && !clr_fall && !pdl_fall && !init_pending |=> dac_a == $past(data))
        else $error("synchronous update missed");
    a_async_only_in: assert property (@(posedge core_clk) disable iff (!rstn) // R17
        frame_exec && cmd == ddc_pkg::DDC_CMD_WRITE_IN && ld_s && override == 2'b00
        && !clr_fall && !pdl_fall && !init_pending |=> $stable(dac_a))
        else $error("strobe high write touched converter");
    a_wake_wait: assert property (@(posedge core_clk) disable iff (!rstn) // R9
        $rose(mode_a == 2'h0) |=> !out_valid_a [*8])
        else $error("output valid too soon after wake");
    a_exit_clear: assert property (@(posedge core_clk) disable iff (!rstn) // R13
        frame_exec && !clr_fall && !pdl_fall |=> !cleared)
        else $error("cleared state not left");
    a_override_sync: assert property (@(posedge core_clk) disable iff (!rstn) // R19
        frame_exec && cmd == ddc_pkg::DDC_CMD_WRITE_IN && addr == 4'h0 && ld_s
        && override[0] && !init_pending |=> dac_a == $past(data))
        else $error("override did not update at once");
    a_clear_noop: assert property (@(posedge core_clk) disable iff (!rstn) // R11
        clr_fall && clear_sel == 2'h3 && !ld_fall && !init_pending
        |=> $stable(in_a) && $stable(dac_a))
        else $error("no-operation clear code changed a register");
    a_power_select: assert property (@(posedge core_clk) disable iff (!rstn) // R7
        frame_exec && cmd == ddc_pkg::DDC_CMD_POWER && !word[`DDC_CHAN_B_BIT]
        && !init_pending |=> $stable(mode_b))
        else $error("unselected channel changed mode");
    a_reset_code: assert property (@(posedge core_clk) disable iff (!rstn) // R3
        frame_exec && cmd == ddc_pkg::DDC_CMD_RESET
        |=> dac_a == $past(por_code) && dac_b == $past(por_code) && override == 2'b00)
        else $error("reset command missed the power-on code");
    // Main scenarios that the bench is expected to reach
    c_power_down: cover property (@(posedge core_clk) disable iff (!rstn)
        frame_exec && cmd == ddc_pkg::DDC_CMD_POWER);
    c_clear: cover property (@(posedge core_clk) disable iff (!rstn) clr_fall);
    c_strobe: cover property (@(posedge core_clk) disable iff (!rstn) ld_fall);
    c_wake: cover property (@(posedge core_clk) disable iff (!rstn) $rose(out_valid_a));
    c_abort: cover property (@(posedge core_clk) disable iff (!rstn)
        fstate == ddc_pkg::DDC_SHIFT && sel_rise);
endmodule : ddc_top
`default_nettype wire

// >>> bench/ddc_host.sv
// Serial host model driving frame select, link clock and data
`timescale 1ns/1ps
`default_nettype none
module ddc_host (
    output logic select_n,
    output logic serial_clk,
    output logic serial_din
);
    initial begin
        select_n = 1'b1;
        serial_clk = 1'b1;
        serial_din = 1'b0;
    end
    // Fewer than 32 bits gives an interrupted frame
    task automatic send(input logic [31:0] f, input int n);
        select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_din = f[31 - i];
            #32 serial_clk = 1'b0;
            #32 serial_clk = 1'b1;
        end
        #32 select_n = 1'b1;
        // Released line flips so stale data never reads as a bit
        serial_din = ~serial_din;
        #96;
    endtask : send
endmodule : ddc_host
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the dual converter control
`timescale 1ns/1ps
`default_nettype none
`include "ddc_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t value differs", $time); end end
module tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic load_outputs_n = 1'b0;
    logic async_clear_n = 1'b1;
    logic powerdown_lockout_n = 1'b1;
    logic por_level = 1'b0;
    wire select_n;
    wire serial_clk;
    wire serial_din;
    logic [15:0] oa, ob;
    logic [1:0] ma, mb;
    logic va, vb, cleared, chain;
    int err_count = 0;
    int n_compared = 0;
    int cnt;
    always #2.5 core_clk = ~core_clk;
    ddc_host host (.select_n(select_n), .serial_clk(serial_clk), .serial_din(serial_din));
    ddc_top dut (.core_clk(core_clk), .rstn(rstn), .select_n(select_n),
        .serial_clk(serial_clk), .serial_din(serial_din), .load_outputs_n(load_outputs_n),
        .async_clear_n(async_clear_n), .powerdown_lockout_n(powerdown_lockout_n),
        .por_level(por_level), .out_code_a(oa), .out_code_b(ob), .out_mode_a(ma),
        .out_mode_b(mb), .out_valid_a(va), .out_valid_b(vb), .cleared(cleared),
        .chain_enable(chain));
    // ********************
    // Frame helpers
    // ********************
    function automatic logic [31:0] fr(input logic [3:0] c, input logic [3:0] a,
        input logic [19:0] lo);
        return {4'h0, c, a, lo};
    endfunction : fr
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle
    task automatic send(input logic [31:0] f, input int n);
        host.send(f, n);
        idle(20);
    endtask : send
    task automatic wr(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        send(fr(c, a, {d, 4'h0}), 32);
    endtask : wr
    task automatic clr_pulse;
        async_clear_n = 1'b0;
        idle(20);
        async_clear_n = 1'b1;
        idle(10);
    endtask : clr_pulse
    task automatic finish_test;
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // ********************
    // Scenarios
    // ********************
    task automatic t_update;
        send(fr(4'h3, `DDC_ADDR_A, 20'h12340), 16);
        `CHK(oa, `DDC_CODE_ZERO)
        `CHK(ob, `DDC_CODE_ZERO)
        wr(4'h0, `DDC_ADDR_A, 16'h1234);
        `CHK(oa, 16'h1234)
        load_outputs_n = 1'b1;
        wr(4'h0, `DDC_ADDR_B, 16'h5678);
        `CHK(ob, `DDC_CODE_ZERO)
        load_outputs_n = 1'b0;
        idle(20);
        `CHK(ob, 16'h5678)
        load_outputs_n = 1'b1;
        wr(4'h0, `DDC_ADDR_A, 16'hAAAA);
        wr(4'h2, `DDC_ADDR_B, 16'h0F0F);
        `CHK(oa, 16'hAAAA)
        send(fr(4'h6, 4'h0, 20'h00001), 32);
        wr(4'h0, `DDC_ADDR_A, 16'h4321);
        wr(4'h0, `DDC_ADDR_B, 16'h1111);
        `CHK(oa, 16'h4321)
        `CHK(ob, 16'h0F0F)
        send(fr(4'h6, 4'h0, 20'h00000), 32);
    endtask : t_update
    task automatic t_power;
        for (int m = 1; m < 4; m++) begin
            send(fr(4'h4, 4'h0, {10'h0, 2'(m), 8'h01}), 32);
            `CHK(ma, 2'(m))
            `CHK(mb, 2'h0)
            `CHK(oa, 16'h4321)
        end
        send(fr(4'h4, 4'h0, {10'h0, 2'h2, 8'h08}), 32);
        `CHK(mb, 2'h2)
        `CHK(vb, 1'b0)
        wr(4'h0, `DDC_ADDR_A, 16'h7777);
        // No trailing idle, so the wake count starts close to the frame end
        host.send(fr(4'h4, 4'h0, {10'h0, 2'h0, 8'h01}), 32);
        `CHK(ma, 2'h0)
        `CHK(oa, 16'h4321)
        `CHK(va, 1'b0)
        for (cnt = 0; cnt < 1000 && va !== 1'b1; cnt++) idle(1);
        `CHK(cnt >= 860 && cnt <= 900, 1'b1)
    endtask : t_power
    task automatic t_lockout;
        powerdown_lockout_n = 1'b0;
        idle(20);
        `CHK(mb, 2'h0)
        send(fr(4'h4, 4'h0, {10'h0, 2'h1, 8'h01}), 32);
        `CHK(ma, 2'h0)
        powerdown_lockout_n = 1'b1;
        idle(10);
        fork
            host.send(fr(4'h3, `DDC_ADDR_A, 20'h22220), 32);
            begin #1000; @(negedge core_clk) powerdown_lockout_n = 1'b0; end
        join
        idle(20);
        `CHK(oa, 16'h4321)
        `CHK(vb, 1'b1)
        powerdown_lockout_n = 1'b1;
    endtask : t_lockout
    task automatic t_clear;
        logic [15:0] exp [3] = '{`DDC_CODE_ZERO, `DDC_CODE_MID, `DDC_CODE_FULL};
        clr_pulse();
        `CHK(oa, `DDC_CODE_ZERO)
        `CHK(cleared, 1'b1)
        for (int c = 0; c < 3; c++) begin
            send(fr(4'h5, 4'h0, 20'(c)), 32);
            clr_pulse();
            `CHK(ob, exp[c])
        end
        fork
            host.send(fr(4'h3, `DDC_ADDR_A, 20'h33330), 32);
            begin #1000; @(negedge core_clk) async_clear_n = 1'b0; end
        join
        idle(20);
        async_clear_n = 1'b1;
        `CHK(oa, `DDC_CODE_FULL)
        wr(4'h3, `DDC_ADDR_A, 16'h3333);
        `CHK(cleared, 1'b0)
        send(fr(4'h5, 4'h0, 20'h00003), 32);
        clr_pulse();
        `CHK(oa, 16'h3333)
        send(fr(4'h8, 4'h0, 20'h00002), 32);
        `CHK(chain, 1'b1)
        load_outputs_n = 1'b0;
        idle(6);
        load_outputs_n = 1'b1;
        idle(10);
        `CHK(oa, 16'h3333)
        por_level = 1'b1;
        send(fr(4'h7, 4'h0, 20'h00000), 32);
        `CHK(ob, `DDC_CODE_MID)
        `CHK(chain, 1'b0)
    endtask : t_clear
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
    initial begin
        idle(8);
        rstn = 1'b1;
        idle(20);
        t_update();
        t_power();
        t_lockout();
        t_clear();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
